/* rtl/clock_config_defines.vh */
/*
 * constants for the codec clock configuration block: register addresses,
 * field positions, select codes, rates and the system clock figure.
 * assumes it is included by its bare name from the rtl files only.
 */
`ifndef CLOCK_CONFIG_DEFINES_VH
`define CLOCK_CONFIG_DEFINES_VH

// register addresses on the 7-bit control port
`define ADDR_SYNTH_CONTROL_ONE 7'h74
`define ADDR_SYNTH_CONTROL_TWO 7'h75
`define ADDR_CONVERTER_CLOCK_SELECT 7'h76

// reset values (none documented, all fields come up at zero)
`define RESET_SYNTH_CONTROL_ONE 8'h00
`define RESET_SYNTH_CONTROL_TWO 8'h00
`define RESET_CONVERTER_CLOCK_SELECT 8'h00

// synth_control_one fields
`define OUT3_SEL_HI 7
`define OUT3_SEL_LO 6
`define MASTER_OUT_HALVE_BIT 5
`define CRYSTAL_REF_HALVE_BIT 4
`define SYNTH_B_PD_BIT 3
`define SYNTH_A_PD_BIT 2
`define OSC_PD_BIT 1
`define OUT3_RATIO_BIT 0

// synth_control_two fields
`define SYNTH_B_RATE_HI 7
`define SYNTH_B_RATE_LO 6
`define SYNTH_B_OVS_BIT 5
`define SYNTH_B_DBL_BIT 4
`define SYNTH_A_RATE_HI 3
`define SYNTH_A_RATE_LO 2
`define SYNTH_A_OVS_BIT 1
`define SYNTH_A_DBL_BIT 0

// converter_clock_select fields
`define PLAYBACK_SRC_HI 7
`define PLAYBACK_SRC_LO 5
`define RECORD_SRC_HI 4
`define RECORD_SRC_LO 2
`define INT_B_SRC_HI 1
`define INT_B_SRC_LO 0

// select codes
`define OUT3_FROM_SYNTH 2'h0
`define OUT3_FROM_RECOVERED 2'h3
`define RATE_CODE_48K 2'h0
`define RATE_CODE_32K 2'h2
`define RATE_CODE_44K1 2'h3

// sample rates in Hz and oversample ratios
`define RATE_48K_HZ 32'd48000
`define RATE_32K_HZ 32'd32000
`define RATE_44K1_HZ 32'd44100
`define RATIO_256 32'd256
`define RATIO_384 32'd384
`define RATIO_512 32'd512

// system clock rate in Hz
`define SYS_CLK_HZ 32'd50000000

`endif

/* rtl/clock_halver.v */
/*
 * optional divide-by-two of a sampled clock level.
 * assumes src_i is a level already synchronous to clk_sys_i.
 */
`timescale 1ns/10ps
module clock_halver (
    input wire clk_sys_i, // system clock
    input wire rst_i, // asynchronous reset, active high
    input wire src_i, // sampled source clock level
    input wire halve_i, // 1: divide by two, 0: pass through
    output reg clk_o // resulting clock level
);

reg src_prev;
reg half;

// toggle on each rising edge of the source, pick halved or plain
always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        src_prev <= 1'b0;
        half <= 1'b0;
        clk_o <= 1'b0;
    end else begin
        src_prev <= src_i;
        if (src_i && !src_prev) begin
            half <= ~half;
        end
        clk_o <= halve_i ? half : src_i;
    end
end

endmodule // clock_halver

/* rtl/clock_switch.v */
/*
 * glitch-free selector among sampled clock levels.
 * assumes all sources are levels synchronous to clk_sys_i; a change of
 * select waits until the output is low, then the new source passes only
 * after it has itself been seen low, so no runt pulse is produced.
 */
`timescale 1ns/10ps
module clock_switch #(
    parameter SEL_W = 3
) (
    input wire clk_sys_i, // system clock
    input wire rst_i, // asynchronous reset, active high
    input wire [(1<<SEL_W)-1:0] src_i, // source clock levels
    input wire [SEL_W-1:0] sel_i, // requested source
    output reg clk_o // selected clock level
);

reg [SEL_W-1:0] active_sel;
reg gate_open;

// switch only while the output is low, reopen on a low of the new source
always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        active_sel <= {SEL_W{1'b0}};
        gate_open <= 1'b0;
        clk_o <= 1'b0;
    end else begin
        if ((sel_i != active_sel) && !clk_o) begin
            active_sel <= sel_i;
            gate_open <= 1'b0;
            clk_o <= 1'b0;
        end else begin
            if (!src_i[active_sel]) begin
                gate_open <= 1'b1;
            end
            clk_o <= gate_open & src_i[active_sel];
        end
    end
end

endmodule // clock_switch

/* rtl/audio_codec_clock_config.v */
/*
 * clock generation and selection for an audio codec: control registers,
 * two rate synthesizers and a third system clock generator modelled as
 * phase accumulators, divide-by-two options and glitch-free selectors.
 * assumes every clock input is a level synchronous to clk_sys_i and that
 * the control port is a simple synchronous read/write strobe port.
 */
`timescale 1ns/10ps
`include "clock_config_defines.vh"
module audio_codec_clock_config (
    input wire clk_sys_i, // system clock, 50 MHz
    input wire rst_i, // asynchronous reset, active high
    input wire reg_write_i, // register write strobe
    input wire reg_read_i, // register read strobe
    input wire [6:0] reg_addr_i, // register address
    input wire [7:0] reg_wdata_i, // register write data
    output reg [7:0] reg_rdata_o, // register read data
    output reg reg_ack_o, // one-cycle answer to any access
    input wire crystal_input_i, // crystal clock level
    input wire master_clock_input_i, // master clock input level
    input wire recovered_512_i, // receiver recovered clock at 512 fs
    input wire recovered_256_i, // receiver recovered clock at 256 fs
    output reg master_clock_output_o, // master clock output
    output reg synth_ref_clock_o, // synthesizer reference clock
    output reg synth_a_internal_clock_o, // synthesizer A clock
    output reg synth_b_internal_clock_o, // synthesizer B clock
    output reg system_out_three_o, // third system clock output
    output reg playback_conv_clock_o, // playback converter clock
    output reg record_conv_clock_o, // record converter clock
    output reg internal_clock_b_o, // internal clock B
    output reg synth_a_powerdown_o, // synthesizer A powered down
    output reg synth_b_powerdown_o, // synthesizer B powered down
    output reg oscillator_powerdown_o // crystal oscillator powered down
);

reg [7:0] synth_control_one;
reg [7:0] synth_control_two;
reg [7:0] converter_clock_select;

// field views of the control registers
wire [1:0] out3_recovered_select = synth_control_one[`OUT3_SEL_HI:`OUT3_SEL_LO];
wire master_out_halve = synth_control_one[`MASTER_OUT_HALVE_BIT];
wire crystal_ref_halve = synth_control_one[`CRYSTAL_REF_HALVE_BIT];
wire synth_b_powerdown = synth_control_one[`SYNTH_B_PD_BIT];
wire synth_a_powerdown = synth_control_one[`SYNTH_A_PD_BIT];
wire oscillator_powerdown = synth_control_one[`OSC_PD_BIT];
wire out3_ratio = synth_control_one[`OUT3_RATIO_BIT];
wire [1:0] synth_b_rate_code = synth_control_two[`SYNTH_B_RATE_HI:`SYNTH_B_RATE_LO];
wire synth_b_oversample = synth_control_two[`SYNTH_B_OVS_BIT];
wire synth_b_double = synth_control_two[`SYNTH_B_DBL_BIT];
wire [1:0] synth_a_rate_code = synth_control_two[`SYNTH_A_RATE_HI:`SYNTH_A_RATE_LO];
wire synth_a_oversample = synth_control_two[`SYNTH_A_OVS_BIT];
wire synth_a_double = synth_control_two[`SYNTH_A_DBL_BIT];
wire [2:0] playback_conv_clock_src = converter_clock_select[`PLAYBACK_SRC_HI:`PLAYBACK_SRC_LO];
wire [2:0] record_conv_clock_src = converter_clock_select[`RECORD_SRC_HI:`RECORD_SRC_LO];
wire [1:0] internal_clock_b_src = converter_clock_select[`INT_B_SRC_HI:`INT_B_SRC_LO];

// base sample rate of a rate code; the reserved code falls back to 48 kHz
function [31:0] rate_hz;
    input [1:0] code;
    begin
        case (code)
            `RATE_CODE_32K: rate_hz = `RATE_32K_HZ;
            `RATE_CODE_44K1: rate_hz = `RATE_44K1_HZ;
            default: rate_hz = `RATE_48K_HZ;
        endcase
    end
endfunction

// synthesizer output frequency: rate times oversample, optionally doubled
function [31:0] synth_hz;
    input [1:0] code;
    input ovs;
    input dbl;
    reg [31:0] base;
    begin
        base = rate_hz(code) * (ovs ? `RATIO_384 : `RATIO_256);
        synth_hz = dbl ? {base[30:0], 1'b0} : base;
    end
endfunction

// register writes; reads answer with the stored value, unmapped read zero
always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        synth_control_one <= `RESET_SYNTH_CONTROL_ONE;
        synth_control_two <= `RESET_SYNTH_CONTROL_TWO;
        converter_clock_select <= `RESET_CONVERTER_CLOCK_SELECT;
        reg_rdata_o <= 8'h00;
        reg_ack_o <= 1'b0;
    end else begin
        reg_ack_o <= reg_write_i | reg_read_i;
        if (reg_write_i) begin
            if (reg_addr_i == `ADDR_SYNTH_CONTROL_ONE) begin
                synth_control_one <= reg_wdata_i;
            end else if (reg_addr_i == `ADDR_SYNTH_CONTROL_TWO) begin
                synth_control_two <= reg_wdata_i;
            end else if (reg_addr_i == `ADDR_CONVERTER_CLOCK_SELECT) begin
                converter_clock_select <= reg_wdata_i;
            end
        end
        if (reg_read_i) begin
            if (reg_addr_i == `ADDR_SYNTH_CONTROL_ONE) begin
                reg_rdata_o <= synth_control_one;
            end else if (reg_addr_i == `ADDR_SYNTH_CONTROL_TWO) begin
                reg_rdata_o <= synth_control_two;
            end else if (reg_addr_i == `ADDR_CONVERTER_CLOCK_SELECT) begin
                reg_rdata_o <= converter_clock_select;
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end
end

// crystal oscillator output, held low while powered down
reg crystal_live;
always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        crystal_live <= 1'b0;
    end else begin
        crystal_live <= crystal_input_i & ~oscillator_powerdown;
    end
end

// master clock output, optionally halved
wire master_out_w;
clock_halver u_master_halver (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .src_i(master_clock_input_i),
    .halve_i(master_out_halve),
    .clk_o(master_out_w)
);

// synthesizer reference from the crystal, optionally halved
wire synth_ref_w;
clock_halver u_ref_halver (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .src_i(crystal_live),
    .halve_i(crystal_ref_halve),
    .clk_o(synth_ref_w)
);

// target frequencies: 0 synthesizer A, 1 synthesizer B, 2 third output
wire [95:0] gen_freq;
wire [2:0] gen_run;
assign gen_freq[31:0] = synth_hz(synth_a_rate_code, synth_a_oversample, synth_a_double);
assign gen_freq[63:32] = synth_hz(synth_b_rate_code, synth_b_oversample, synth_b_double);
assign gen_freq[95:64] = rate_hz(synth_a_rate_code) * (out3_ratio ? `RATIO_256 : `RATIO_512);
assign gen_run[0] = ~synth_a_powerdown & ~oscillator_powerdown;
assign gen_run[1] = ~synth_b_powerdown & ~oscillator_powerdown;
assign gen_run[2] = ~synth_a_powerdown & ~oscillator_powerdown;

// phase accumulators: toggle each time the half-period budget wraps
wire [2:0] gen_clk;
genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : gen_nco
        reg [31:0] acc;
        reg level;
        wire [31:0] step = {gen_freq[32*g+30:32*g], 1'b0};
        wire [32:0] sum = {1'b0, acc} + {1'b0, step};
        always @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                acc <= 32'h00000000;
                level <= 1'b0;
            end else if (!gen_run[g]) begin
                acc <= 32'h00000000;
                level <= 1'b0;
            end else if (step >= `SYS_CLK_HZ) begin
                level <= ~level;
            end else if (sum >= {1'b0, `SYS_CLK_HZ}) begin
                acc <= sum[31:0] - `SYS_CLK_HZ;
                level <= ~level;
            end else begin
                acc <= sum[31:0];
            end
        end
        assign gen_clk[g] = level;
    end
endgenerate

// third output: synthesizer block or recovered clock at the chosen ratio
wire out3_from_rec = (out3_recovered_select == `OUT3_FROM_RECOVERED);
// ratio and source both pass the switch; a ratio change between the recovered clocks cannot cut a pulse short, but gen_clk[2] retunes at once
wire [1:0] out3_pick = {out3_from_rec, out3_ratio};
wire out3_w;
clock_switch #(
    .SEL_W(2)
) u_out3_switch (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .src_i({recovered_256_i, recovered_512_i, gen_clk[2], gen_clk[2]}),
    .sel_i(out3_pick),
    .clk_o(out3_w)
);

// shared eight-way source set for both converter selectors
wire [7:0] conv_sources = {
    crystal_live, // code 111
    crystal_live, // code 110
    recovered_256_i, // code 101, receiver at 256 fs
    recovered_512_i, // code 100, receiver at 512 fs
    gen_clk[1], // code 011, synthesizer B
    gen_clk[0], // code 010, synthesizer A
    master_clock_input_i, // code 001
    crystal_live // code 000
};

// playback converter clock
wire playback_w;
clock_switch #(
    .SEL_W(3)
) u_playback_switch (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .src_i(conv_sources),
    .sel_i(playback_conv_clock_src),
    .clk_o(playback_w)
);

// record converter clock
wire record_w;
clock_switch #(
    .SEL_W(3)
) u_record_switch (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .src_i(conv_sources),
    .sel_i(record_conv_clock_src),
    .clk_o(record_w)
);

// internal clock B, four-way source set
wire [3:0] internal_b_sources = {
    gen_clk[1], // code 11, synthesizer B
    gen_clk[0], // code 10, synthesizer A
    master_clock_input_i, // code 01
    crystal_live // code 00
};
wire internal_b_w;
clock_switch #(
    .SEL_W(2)
) u_internal_b_switch (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .src_i(internal_b_sources),
    .sel_i(internal_clock_b_src),
    .clk_o(internal_b_w)
);

// output flops
always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
        master_clock_output_o <= 1'b0;
        synth_ref_clock_o <= 1'b0;
        synth_a_internal_clock_o <= 1'b0;
        synth_b_internal_clock_o <= 1'b0;
        system_out_three_o <= 1'b0;
        playback_conv_clock_o <= 1'b0;
        record_conv_clock_o <= 1'b0;
        internal_clock_b_o <= 1'b0;
        synth_a_powerdown_o <= 1'b0;
        synth_b_powerdown_o <= 1'b0;
        oscillator_powerdown_o <= 1'b0;
    end else begin
        master_clock_output_o <= master_out_w;
        synth_ref_clock_o <= synth_ref_w;
        synth_a_internal_clock_o <= gen_clk[0];
        synth_b_internal_clock_o <= gen_clk[1];
        system_out_three_o <= out3_w;
        playback_conv_clock_o <= playback_w;
        record_conv_clock_o <= record_w;
        internal_clock_b_o <= internal_b_w;
        synth_a_powerdown_o <= synth_a_powerdown;
        synth_b_powerdown_o <= synth_b_powerdown;
        oscillator_powerdown_o <= oscillator_powerdown;
    end
end

endmodule // audio_codec_clock_config

/* dv/clock_config_props.sv */
/*
 * concurrent checks on the ports of the codec clock configuration block.
 * assumes it is bound to audio_codec_clock_config with one 50 MHz clock.
 */
`timescale 1ns/10ps
module clock_config_props (
    input wire clk_sys_i, // system clock
    input wire rst_i, // asynchronous reset, active high
    input wire reg_write_i, // write strobe
    input wire reg_read_i, // read strobe
    input wire [6:0] reg_addr_i, // register address
    input wire [7:0] reg_wdata_i, // write data
    input wire [7:0] reg_rdata_o, // read data
    input wire reg_ack_o, // access answer
    input wire crystal_input_i, // crystal level
    input wire master_clock_input_i, // master input level
    input wire master_clock_output_o, // master output
    input wire synth_ref_clock_o, // synthesizer reference
    input wire synth_a_internal_clock_o, // synthesizer a clock
    input wire synth_b_internal_clock_o, // synthesizer b clock
    input wire synth_a_powerdown_o, // synthesizer a down
    input wire synth_b_powerdown_o, // synthesizer b down
    input wire oscillator_powerdown_o // oscillator down
);
    reg [7:0] ctl1;
    reg [3:0] quiet;
    wire is_map = reg_addr_i >= 7'h74 && reg_addr_i <= 7'h76;

    // mirror of the first control register and cycles since its last write
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctl1 <= 8'h00;
            quiet <= 4'h0;
        end else if (reg_write_i && reg_addr_i == 7'h74) begin
            ctl1 <= reg_wdata_i;
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    property p_ack; (reg_write_i || reg_read_i) |=> reg_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("access not answered");
    property p_rdata; reg_read_i && reg_addr_i == 7'h74 |=> reg_rdata_o == $past(ctl1); endproperty
    a_rdata: assert property (p_rdata) else $error("first control register reads wrong");
    property p_unmapped; reg_read_i && !is_map |=> reg_rdata_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_pd;
        reg_write_i && reg_addr_i == 7'h74 |->
            ##2 {synth_b_powerdown_o, synth_a_powerdown_o, oscillator_powerdown_o} == $past(reg_wdata_i[3:1], 2);
    endproperty
    a_pd: assert property (p_pd) else $error("powerdown outputs wrong");
    property p_osc_off;
        oscillator_powerdown_o [*8] |-> !synth_ref_clock_o && !synth_a_internal_clock_o && !synth_b_internal_clock_o;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("clock runs with oscillator down");
    property p_a_off; synth_a_powerdown_o [*8] |-> !synth_a_internal_clock_o; endproperty
    a_a_off: assert property (p_a_off) else $error("synthesizer a runs while down");
    property p_b_off; synth_b_powerdown_o [*8] |-> !synth_b_internal_clock_o; endproperty
    a_b_off: assert property (p_b_off) else $error("synthesizer b runs while down");
    property p_mclk; quiet > 4'h8 && !ctl1[5] |-> master_clock_output_o == $past(master_clock_input_i, 2); endproperty
    a_mclk: assert property (p_mclk) else $error("master output not a copy");
    property p_ref;
        quiet > 4'h8 && !ctl1[4] && !ctl1[1] |-> synth_ref_clock_o == $past(crystal_input_i, 3);
    endproperty
    a_ref: assert property (p_ref) else $error("reference not the crystal");

    // main scenarios reached
    c_unmapped: cover property (reg_read_i && !is_map);
    c_halved: cover property (quiet > 4'h8 && ctl1[5] && $rose(master_clock_output_o));
    c_osc_off: cover property (oscillator_powerdown_o [*8]);
endmodule // clock_config_props

bind audio_codec_clock_config clock_config_props u_props (.*);

/* dv/tb_audio_codec_clock_config.sv */
/*
 * self-checking bench for the codec clock configuration block.
 * assumes the port checker is bound from its own file; clock rates are
 * judged by counting rising edges over a window of system cycles.
 */
`timescale 1ns/10ps
module tb_audio_codec_clock_config;
    localparam longint SRC_HZ [0:7] = '{12500000, 8333333, 8192000, 18432000, 6250000, 5000000, 12500000, 12500000};
    reg clk_sys_i = 1'b0;
    reg rst_i = 1'b1;
    reg we = 1'b0;
    reg re = 1'b0;
    reg [6:0] addr = 7'h00;
    reg [7:0] wdata = 8'h00;
    reg [7:0] rd;
    reg xtal = 1'b0;
    reg mclk = 1'b0;
    reg r512 = 1'b0;
    reg r256 = 1'b0;
    wire [7:0] rdata;
    wire [7:0] obs;
    wire ack, pda, pdb, pdo;
    integer cyc = 0, bad_count = 0, tests_run = 0, k, i, j;
    integer rises [0:7];

    audio_codec_clock_config DUT (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_write_i(we), .reg_read_i(re), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .crystal_input_i(xtal),
        .master_clock_input_i(mclk), .recovered_512_i(r512), .recovered_256_i(r256),
        .master_clock_output_o(obs[0]), .synth_ref_clock_o(obs[1]), .synth_a_internal_clock_o(obs[2]),
        .synth_b_internal_clock_o(obs[3]), .system_out_three_o(obs[4]), .playback_conv_clock_o(obs[5]),
        .record_conv_clock_o(obs[6]), .internal_clock_b_o(obs[7]), .synth_a_powerdown_o(pda),
        .synth_b_powerdown_o(pdb), .oscillator_powerdown_o(pdo)
    );

    // system clock, 20 ns period
    always #10 clk_sys_i = ~clk_sys_i;

    // source clocks with periods of 4, 6, 8 and 10 system cycles
    always @(negedge clk_sys_i) begin
        cyc <= cyc + 1;
        xtal <= (cyc % 4) >= 2;
        mclk <= (cyc % 6) >= 3;
        r512 <= (cyc % 8) >= 4;
        r256 <= (cyc % 10) >= 5;
    end

    task check(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, bad_count);
            if (bad_count == 0 && tests_run > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask

    // one strobe cycle, then a bounded wait for the answer
    task bus(input w, input [6:0] a, input [7:0] d);
        integer n;
        begin
            @(negedge clk_sys_i);
            we = w;
            re = !w;
            addr = a;
            wdata = d;
            @(negedge clk_sys_i);
            we = 1'b0;
            re = 1'b0;
            n = 0;
            while (ack !== 1'b1 && n < 3) begin
                @(negedge clk_sys_i);
                n = n + 1;
            end
            if (n == 3) begin
                bad_count = bad_count + 1;
                give_verdict;
            end
            rd = rdata;
        end
    endtask

    task rchk(input [6:0] a, input [7:0] exp);
        begin
            bus(1'b0, a, 8'h00);
            check(rd, exp);
        end
    endtask

    // rising edges of every observed clock over n cycles
    task count(input integer n);
        reg [7:0] prev;
        begin
            for (i = 0; i < 8; i = i + 1) rises[i] = 0;
            prev = obs;
            repeat (n) begin
                @(negedge clk_sys_i);
                for (i = 0; i < 8; i = i + 1) rises[i] = rises[i] + (obs[i] & !prev[i]);
                prev = obs;
            end
        end
    endtask

    // edge count within two of the figure implied by hz, capped at half the system rate
    task near(input integer idx, input longint hz, input integer n);
        integer e;
        begin
            e = (hz > 25000000 ? 25000000 : hz) * n / 50000000;
            check((rises[idx] >= e - 2 && rises[idx] <= e + 2) ? e : rises[idx], e);
        end
    endtask

    function integer rate(input integer c);
        rate = c == 0 ? 48000 : c == 2 ? 32000 : 44100;
    endfunction

    // main sequence
    initial begin
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        for (k = 0; k < 4; k = k + 1) rchk(7'h73 + k, 8'h00);
        bus(1'b1, 7'h77, 8'hFF);
        rchk(7'h77, 8'h00);
        bus(1'b1, 7'h74, 8'hCE);
        bus(1'b1, 7'h75, 8'hEB);
        bus(1'b1, 7'h76, 8'hB7);
        rchk(7'h74, 8'hCE);
        rchk(7'h75, 8'hEB);
        rchk(7'h76, 8'hB7);
        check({pdb, pda, pdo}, 3'h7);
        bus(1'b1, 7'h74, 8'h04);
        count(10);
        check({pdb, pda, pdo}, 3'h2);
        count(200);
        near(2, 0, 200);
        near(3, 16934400, 200);
        // halving of master output and reference, then oscillator down
        for (k = 0; k < 3; k = k + 1) begin
            bus(1'b1, 7'h74, k == 0 ? 8'h30 : k == 1 ? 8'h00 : 8'h02);
            count(20);
            count(600);
            near(0, k == 0 ? 4166666 : 8333333, 600);
            near(1, k == 0 ? 6250000 : k == 1 ? 12500000 : 0, 600);
            near(2, k == 2 ? 0 : 24576000, 600);
        end
        // every rate code except the reserved one, oversample and doubling on both synthesizers
        bus(1'b1, 7'h74, 8'h00);
        for (k = 0; k < 12; k = k + 1) begin
            j = k / 4 == 0 ? 0 : k / 4 + 1;
            bus(1'b1, 7'h75, {j[1:0], !k[1], k[0], j[1:0], k[1], k[0]});
            count(20);
            count(2000);
            near(2, rate(j) * (k[1] ? 384 : 256) * (k[0] ? 2 : 1), 2000);
            near(3, rate(j) * (k[1] ? 256 : 384) * (k[0] ? 2 : 1), 2000);
        end
        // every converter and internal clock source code
        bus(1'b1, 7'h75, 8'h28);
        for (k = 0; k < 8; k = k + 1) begin
            bus(1'b1, 7'h76, {k[2:0], ~k[2:0], k[1:0]});
            count(30);
            count(600);
            near(5, SRC_HZ[k], 600);
            near(6, SRC_HZ[7 - k], 600);
            near(7, SRC_HZ[k % 4], 600);
        end
        // third output source and ratio
        for (k = 0; k < 4; k = k + 1) begin
            bus(1'b1, 7'h74, {k[1], k[1], 5'h00, k[0]});
            count(30);
            count(600);
            near(4, k[1] ? SRC_HZ[4 + k[0]] : 16384000 >> k[0], 600);
        end
        give_verdict;
    end
endmodule // tb_audio_codec_clock_config
